// [cgopc_pkg.sv]
// Shared constants and carriers for the clock generator control block.
// Assumes a single 25 MHz system clock; slow and main clocks arrive as pins.
package cgopc_pkg;

  // Register offsets
  localparam logic [7:0] OFF_OSC_CTRL  = 8'h20;
  localparam logic [7:0] OFF_FREQ      = 8'h24;
  localparam logic [7:0] OFF_PLL_CFG   = 8'h2C;
  localparam logic [7:0] OFF_STATUS    = 8'h68;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h6C;

  // Oscillator control fields
  localparam int OSC_EN_BIT    = 0;
  localparam int OSC_BYP_BIT   = 1;
  localparam int OSC_CNT_LSB   = 8;
  localparam int OSC_CNT_W     = 8;

  // Frequency register fields
  localparam int FREQ_CNT_W    = 16;
  localparam int FREQ_DONE_BIT = 16;

  // PLL configuration fields
  localparam int PLL_DIV_LSB   = 0;
  localparam int PLL_DIV_W     = 8;
  localparam int PLL_CNT_LSB   = 8;
  localparam int PLL_CNT_W     = 6;
  localparam int PLL_OUT_LSB   = 14;
  localparam int PLL_OUT_W     = 2;
  localparam int PLL_MUL_LSB   = 16;
  localparam int PLL_MUL_W     = 11;

  // Status and mask bits
  localparam int ST_STABLE_BIT = 0;
  localparam int ST_LOCK_BIT   = 2;

  // Timing counts
  localparam int OSC_PRESCALE  = 8;
  localparam int MEAS_PERIODS  = 16;

  // Reset values
  localparam logic [31:0] RST_OSC_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_PLL_CFG  = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;

  typedef struct packed {
    logic [OSC_CNT_W-1:0] startup;
    logic                 bypass;
    logic                 enable;
  } cgopc_osc_cfg_t;

  typedef struct packed {
    logic [PLL_MUL_W-1:0] mul;
    logic [PLL_OUT_W-1:0] out_range;
    logic [PLL_CNT_W-1:0] settle;
    logic [PLL_DIV_W-1:0] div;
  } cgopc_pll_cfg_t;

  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_ARM,
    MEAS_COUNT,
    MEAS_DONE
  } cgopc_meas_state_t;

endpackage

// [cgopc_freq_meter.sv]
// Main clock frequency meter: counts main clock edges over slow periods.
// Expects one-cycle slow edge pulses from the parent, already synchronised.
`timescale 1ns/1ps
`default_nettype none
module cgopc_freq_meter
  import cgopc_pkg::*;
#(
  parameter int CNT_W = FREQ_CNT_W
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             start,
  input  wire logic             slow_rise,
  input  wire logic             slow_fall,
  // Main clock pin
  input  wire logic             main_osc_clock,
  // Result
  output logic [CNT_W-1:0]      count_q,
  output logic                  done_q
);

  logic [2:0]        main_sync_q;
  logic [3:0]        falls_q;
  cgopc_meas_state_t state_q;
  cgopc_meas_state_t state_d;

  wire main_rise = main_sync_q[1] & ~main_sync_q[2];
  wire last_fall = slow_fall && (falls_q == 4'(MEAS_PERIODS - 1));
  wire counting  = (state_q == MEAS_COUNT);
  wire at_max    = &count_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      MEAS_IDLE:  if (start) state_d = MEAS_ARM;
      MEAS_ARM:   if (slow_rise) state_d = MEAS_COUNT;
      MEAS_COUNT: if (last_fall) state_d = MEAS_DONE;
      MEAS_DONE:  state_d = MEAS_DONE;
      default:    state_d = MEAS_IDLE;
    endcase
    if (!start)
      state_d = MEAS_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_sync_q <= 3'h0;
      state_q     <= MEAS_IDLE;
    end
    else
    begin
      main_sync_q <= {main_sync_q[1:0], main_osc_clock};
      state_q     <= state_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= '0;
    else if (state_q == MEAS_IDLE)
      count_q <= '0;
    else if (counting && main_rise && !at_max)
      count_q <= count_q + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      falls_q <= 4'h0;
      done_q  <= 1'b0;
    end
    else if (state_q != MEAS_COUNT)
    begin
      falls_q <= 4'h0;
      done_q  <= (state_d == MEAS_DONE);
    end
    else
    begin
      falls_q <= falls_q + 4'(slow_fall);
      // Stable lost on the last fall must not leave done set
      done_q  <= last_fall && start;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  freeze_result_a: assert property (done_q && $past(done_q) |-> $stable(count_q))
    else $error("frequency count moved after measurement end");
  done_timing_a: assert property (counting && last_fall && start |=> done_q)
    else $error("done flag not set at last slow fall");

endmodule
`default_nettype wire

// [cgopc_top.sv]
// Clock generator control: oscillator start-up, frequency meter, PLL setup.
// Slow and main clocks are pins, sampled on clk; registers on a plain port.
// Functional notes
// - Slow clock is the permanent clock; always-on counters follow its edges.
// - After reset the oscillator is off and the slow clock is selected.
// - Clearing oscillator enable clears the stable flag.
// - Enable write clears stable and loads count into slow/8 down-counter.
// - Start-up count field is eight bits wide.
// - Counter at zero sets stable; masked flag raises the interrupt.
// - Once stable, frequency counting starts after next slow rising edge.
// - Sixteenth slow falling edge stops the count and sets done.
// - Input divider takes values 1 to 255 in unit steps.
// - Divide field zero holds divider and PLL outputs low.
// - Reset clears the divide field, holding the PLL input at zero.
// - PLL output is source times multiplier plus one over divider.
// - Multiplier zero powers the PLL down; nonzero powers it up.
// - Re-enabling or changing PLL settings clears the lock flag.
// - Settle count decrements per slow cycle; zero sets lock.
// - Multiplier field holds 0 to 2047 in eleven bits.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cgopc_top
  import cgopc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Clock pins
  input  wire logic        slow_rc_clock,
  input  wire logic        main_osc_clock,
  // Oscillator controls
  output logic             main_osc_enable,
  output logic             osc_bypass_select,
  output logic             main_osc_stable,
  output logic             main_clk_select,
  // PLL controls
  output cgopc_pll_cfg_t   pll_cfg,
  output logic             pll_powered,
  output logic             pll_clk_hold_low,
  output logic             pll_locked,
  // Interrupt
  output logic             irq
);

  // Configuration and state
  cgopc_osc_cfg_t       osc_cfg_q;
  cgopc_pll_cfg_t       pll_cfg_q;
  logic [31:0]          irq_mask_q;
  logic [2:0]           slow_sync_q;
  logic [2:0]           presc_q;
  logic [OSC_CNT_W-1:0] osc_cnt_q;
  logic                 osc_run_q;
  logic                 stable_q;
  logic [PLL_CNT_W-1:0] pll_cnt_q;
  logic                 pll_run_q;
  logic                 lock_q;
  logic [31:0]          rdata_q;
  logic [FREQ_CNT_W-1:0] freq_count;
  logic                 freq_done;

  // Address decode
  wire wr_osc  = reg_wr && (reg_addr == OFF_OSC_CTRL);
  wire wr_pll  = reg_wr && (reg_addr == OFF_PLL_CFG);
  wire wr_mask = reg_wr && (reg_addr == OFF_IRQ_MASK);

  // Incoming fields of a write
  // eight-bit start-up count
  wire cgopc_osc_cfg_t osc_new = '{
    startup: reg_wdata[OSC_CNT_LSB +: OSC_CNT_W],
    bypass:  reg_wdata[OSC_BYP_BIT],
    enable:  reg_wdata[OSC_EN_BIT]
  };
  wire cgopc_pll_cfg_t pll_new = '{
    mul:       reg_wdata[PLL_MUL_LSB +: PLL_MUL_W],
    out_range: reg_wdata[PLL_OUT_LSB +: PLL_OUT_W],
    settle:    reg_wdata[PLL_CNT_LSB +: PLL_CNT_W],
    div:       reg_wdata[PLL_DIV_LSB +: PLL_DIV_W]
  };

  // Slow clock edges, taken only from the second sync stage onward
  wire slow_rise = slow_sync_q[1] & ~slow_sync_q[2];
  wire slow_fall = ~slow_sync_q[1] & slow_sync_q[2];
  wire osc_tick  = slow_rise && (presc_q == 3'(OSC_PRESCALE - 1));

  // Countdowns finish when the last unit elapses; a zero load finishes on the first step, as a load of one does
  wire osc_last  = (osc_cnt_q <= OSC_CNT_W'(1));
  wire pll_last  = (pll_cnt_q <= PLL_CNT_W'(1));

  wire pll_on_w  = (pll_cfg_q.mul != '0);
  // divide zero gives a flat low
  wire div_off_w = (pll_cfg_q.div == '0);

  wire [31:0] status_w = (32'(stable_q) << ST_STABLE_BIT)
                       | (32'(lock_q) << ST_LOCK_BIT);
  // Only the two flags may be unmasked
  wire [31:0] status_mask_w = (32'h1 << ST_STABLE_BIT) | (32'h1 << ST_LOCK_BIT);

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_cfg_q  <= '{
        startup: RST_OSC_CTRL[OSC_CNT_LSB +: OSC_CNT_W],
        bypass:  RST_OSC_CTRL[OSC_BYP_BIT],
        enable:  RST_OSC_CTRL[OSC_EN_BIT]
      };
      pll_cfg_q  <= cgopc_pll_cfg_t'(RST_PLL_CFG[PLL_MUL_LSB+PLL_MUL_W-1:0]);
      irq_mask_q <= RST_IRQ_MASK;
    end
    else
    begin
      if (wr_osc)
        osc_cfg_q <= osc_new;
      if (wr_pll)
        pll_cfg_q <= pll_new;
      if (wr_mask)
        irq_mask_q <= reg_wdata & status_mask_w;
    end
  end

  // slow clock sampled as the only permanent time base
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      slow_sync_q <= 3'h0;
    else
      slow_sync_q <= {slow_sync_q[1:0], slow_rc_clock};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      presc_q <= 3'h0;
    else if (wr_osc)
      presc_q <= 3'h0;
    else if (slow_rise)
      presc_q <= presc_q + 3'h1;
  end

  // Oscillator start-up countdown
  // A write outranks the tick, so a rewrite with enable set always restarts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_cnt_q <= '0;
      osc_run_q <= 1'b0;
      stable_q  <= 1'b0;
    end
    else if (wr_osc && !osc_new.enable)
    begin
      osc_run_q <= 1'b0;
      stable_q  <= 1'b0;
    end
    else if (wr_osc)
    begin
      osc_cnt_q <= osc_new.startup;
      osc_run_q <= 1'b1;
      stable_q  <= 1'b0;
    end
    else if (osc_run_q && osc_tick)
    begin
      osc_cnt_q <= osc_last ? '0 : osc_cnt_q - 1'b1;
      osc_run_q <= !osc_last;
      stable_q  <= osc_last;
    end
  end

  // PLL settle countdown
  // Lock follows only writes with both mul and div nonzero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_cnt_q <= '0;
      pll_run_q <= 1'b0;
      lock_q    <= 1'b0;
    end
    else if (wr_pll)
    begin
      pll_cnt_q <= pll_new.settle;
      pll_run_q <= (pll_new.mul != '0) && (pll_new.div != '0);
      lock_q    <= 1'b0;
    end
    else if (pll_run_q && slow_rise)
    begin
      pll_cnt_q <= pll_last ? '0 : pll_cnt_q - 1'b1;
      pll_run_q <= !pll_last;
      lock_q    <= pll_last;
    end
  end

  cgopc_freq_meter #(
    .CNT_W (FREQ_CNT_W)
  ) u_meter (
    .clk            (clk),
    .rst_n          (rst_n),
    .start          (stable_q),
    .slow_rise      (slow_rise),
    .slow_fall      (slow_fall),
    .main_osc_clock (main_osc_clock),
    .count_q        (freq_count),
    .done_q         (freq_done)
  );

  // Read mux; unmapped offsets read zero
  wire [31:0] osc_rd_w  = (32'(osc_cfg_q.startup) << OSC_CNT_LSB)
                        | (32'(osc_cfg_q.bypass) << OSC_BYP_BIT)
                        | (32'(osc_cfg_q.enable) << OSC_EN_BIT);
  wire [31:0] freq_rd_w = (32'(freq_done) << FREQ_DONE_BIT) | 32'(freq_count);
  wire [31:0] pll_rd_w  = (32'(pll_cfg_q.mul) << PLL_MUL_LSB)
                        | (32'(pll_cfg_q.out_range) << PLL_OUT_LSB)
                        | (32'(pll_cfg_q.settle) << PLL_CNT_LSB)
                        | (32'(pll_cfg_q.div) << PLL_DIV_LSB);
  wire [31:0] rd_mux_w  = (reg_addr == OFF_OSC_CTRL) ? osc_rd_w  :
                          (reg_addr == OFF_FREQ)     ? freq_rd_w :
                          (reg_addr == OFF_PLL_CFG)  ? pll_rd_w  :
                          (reg_addr == OFF_STATUS)   ? status_w  :
                          (reg_addr == OFF_IRQ_MASK) ? irq_mask_q : 32'h0000_0000;

  // Read data is valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (reg_rd)
      rdata_q <= rd_mux_w;
    else
      rdata_q <= 32'h0000_0000;
  end

  // Outputs
  assign reg_rdata         = rdata_q;
  assign main_osc_enable   = osc_cfg_q.enable;
  assign osc_bypass_select = osc_cfg_q.bypass;
  assign main_osc_stable   = stable_q;
  // slow clock stays selected until the main clock is usable
  assign main_clk_select   = stable_q;
  // factor is (mul + 1) / div, applied by the analogue loop
  assign pll_cfg           = pll_cfg_q;
  assign pll_powered       = pll_on_w;
  assign pll_clk_hold_low  = div_off_w;
  assign pll_locked        = lock_q;
  assign irq               = |(status_w & irq_mask_q);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  osc_off_clear_a: assert property (wr_osc && !osc_new.enable |=> !stable_q)
    else $error("stable flag survived oscillator disable");
  osc_restart_a: assert property (wr_osc && osc_new.enable |=>
      !stable_q && osc_run_q && osc_cnt_q == $past(osc_new.startup))
    else $error("start-up count not reloaded on enable write");
  stable_set_a: assert property (osc_run_q && osc_tick && osc_last && !wr_osc
      |=> stable_q)
    else $error("stable not set when start-up count expired");
  reset_off_a: assert property (!osc_cfg_q.enable |-> !stable_q && !main_clk_select)
    else $error("stable or main select while oscillator off");
  pll_clear_a: assert property (wr_pll |=>
      !lock_q && pll_cnt_q == $past(pll_new.settle))
    else $error("lock not cleared or settle count not loaded");
  lock_set_a: assert property (pll_run_q && slow_rise && pll_last && !wr_pll
      |=> lock_q ##1 lock_q || $past(wr_pll))
    else $error("lock not set when settle count expired");
  div_zero_a: assert property (pll_cfg_q.div == '0 |-> pll_clk_hold_low && !lock_q)
    else $error("divider zero did not hold clock low");
  mul_zero_a: assert property (pll_cfg_q.mul == '0 |-> !pll_powered && !lock_q)
    else $error("PLL powered or locked with zero multiplier");
  done_clear_a: assert property (!stable_q |=> !freq_done)
    else $error("measurement done flag outlived stable flag");
  read_lat_a: assert property (reg_rd && reg_addr == OFF_STATUS
      |=> reg_rdata[ST_LOCK_BIT] == $past(lock_q))
    else $error("status read returned wrong lock value");
  irq_mask_a: assert property (irq |->
      (stable_q && irq_mask_q[ST_STABLE_BIT]) || (lock_q && irq_mask_q[ST_LOCK_BIT]))
    else $error("interrupt raised without an enabled flag");

  // Prescaler, countdown and field checks
  osc_off_run_a: assert property (wr_osc && !osc_new.enable |=> !osc_run_q)
    else $error("countdown kept running after disable");
  presc_clear_a: assert property (wr_osc |=> presc_q == 3'h0)
    else $error("prescaler not cleared by oscillator write");
  presc_step_a: assert property (slow_rise && !wr_osc
      |=> presc_q == $past(presc_q) + 3'h1)
    else $error("prescaler missed a slow rising edge");
  osc_step_a: assert property (osc_run_q && osc_tick && !osc_last && !wr_osc
      |=> osc_run_q && osc_cnt_q == $past(osc_cnt_q) - 1'b1)
    else $error("start-up count did not step on divided tick");
  osc_hold_a: assert property (osc_run_q && !osc_tick && !wr_osc
      |=> $stable(osc_cnt_q) && !stable_q)
    else $error("start-up count moved between divided ticks");
  osc_reload_a: assert property (wr_osc && osc_new.enable && osc_run_q
      |=> osc_run_q && osc_cnt_q == $past(osc_new.startup))
    else $error("rewrite during countdown did not restart it");
  startup_field_a: assert property (wr_osc
      |=> osc_cfg_q.startup == $past(reg_wdata[OSC_CNT_LSB +: OSC_CNT_W]))
    else $error("start-up count field not stored in full");
  stable_hold_a: assert property (stable_q && !wr_osc |=> stable_q)
    else $error("stable flag dropped without a write");
  div_store_a: assert property (wr_pll
      |=> pll_cfg_q.div == $past(reg_wdata[PLL_DIV_LSB +: PLL_DIV_W]))
    else $error("divide value not stored as written");
  mul_store_a: assert property (wr_pll
      |=> pll_cfg_q.mul == $past(reg_wdata[PLL_MUL_LSB +: PLL_MUL_W]))
    else $error("multiplier not stored in eleven bits");
  pll_step_a: assert property (pll_run_q && slow_rise && !pll_last && !wr_pll
      |=> pll_run_q && pll_cnt_q == $past(pll_cnt_q) - 1'b1)
    else $error("settle count did not step on slow edge");
  pll_hold_a: assert property (pll_run_q && !slow_rise && !wr_pll
      |=> $stable(pll_cnt_q) && !lock_q)
    else $error("settle count moved without a slow edge");
  pll_stay_a: assert property (lock_q && !wr_pll |=> lock_q)
    else $error("lock dropped without a PLL write");
  pll_idle_a: assert property (wr_pll && (pll_new.mul == '0 || pll_new.div == '0)
      |=> !pll_run_q && !lock_q)
    else $error("settle count ran with PLL off");
  mask_bits_a: assert property ((irq_mask_q & ~status_mask_w) == 32'h0000_0000)
    else $error("interrupt mask holds an unused bit");

endmodule
`default_nettype wire

// [cgopc_clk_src.sv]
// Far-side model: free-running slow RC clock and the main oscillator source.
// Assumes enable and bypass come straight from the control block outputs.
`timescale 1ns/1ps
`default_nettype none
module cgopc_clk_src
#(
  parameter int SLOW_PER_NS = 640,
  parameter int MAIN_PER_NS = 160
)
(
  // Controls from the block
  input  wire logic osc_enable,
  input  wire logic osc_bypass,
  // Clock pins
  output var logic  slow_rc_clock,
  output var logic  main_osc_clock
);
  // Odd offset keeps the slow clock off the system clock phase
  initial
  begin
    slow_rc_clock = 1'b0;
    #7;
    forever #(SLOW_PER_NS / 2) slow_rc_clock = ~slow_rc_clock;
  end

  // external clock on crystal input
  // Stopped source stands low; no swing without enable or bypass
  initial
  begin
    main_osc_clock = 1'b0;
    #13;
    forever
    begin
      if (osc_enable || osc_bypass)
        #(MAIN_PER_NS / 2) main_osc_clock = ~main_osc_clock;
      else
      begin
        main_osc_clock = 1'b0;
        @(osc_enable or osc_bypass);
      end
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the clock generator control block.
// Assumes the far-side model supplies the slow and main clock pins.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cgopc_pkg::*;
;
  localparam int SP      = 16;
  localparam int MP      = 4;
  localparam int NOM     = 16 * SP / MP;
  localparam int TIMEOUT = 20000;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
  } cgopc_tb_row_t;

  logic           clk;
  logic           rst_n;
  logic [7:0]     reg_addr;
  logic [31:0]    reg_wdata;
  logic           reg_wr;
  logic           reg_rd;
  logic [31:0]    reg_rdata;
  logic           slow_rc_clock;
  logic           main_osc_clock;
  logic           main_osc_enable;
  logic           osc_bypass_select;
  logic           main_osc_stable;
  logic           main_clk_select;
  cgopc_pll_cfg_t pll_cfg;
  logic           pll_powered;
  logic           pll_clk_hold_low;
  logic           pll_locked;
  logic           irq;
  int             fail_count;
  int             tests_run;
  int             cycles;
  int             n;
  int             k;
  logic [31:0]    rd;
  logic [31:0]    rd2;

  // Writable registers keep only their field bits; read-only and unmapped places must swallow writes
  cgopc_tb_row_t rows [7] = '{
    '{OFF_OSC_CTRL, 32'hFFFF_FF02, 32'h0000_FF02},
    '{OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0005},
    '{OFF_IRQ_MASK, 32'h0000_0000, 32'h0000_0000},
    '{OFF_FREQ,     32'hFFFF_FFFF, 32'h0000_0000},
    '{OFF_STATUS,   32'hFFFF_FFFF, 32'h0000_0000},
    '{8'h30,        32'hFFFF_FFFF, 32'h0000_0000},
    '{OFF_PLL_CFG,  32'hFFFF_0000, 32'h07FF_0000}
  };

  cgopc_top dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slow_rc_clock(slow_rc_clock), .main_osc_clock(main_osc_clock),
    .main_osc_enable(main_osc_enable), .osc_bypass_select(osc_bypass_select),
    .main_osc_stable(main_osc_stable), .main_clk_select(main_clk_select),
    .pll_cfg(pll_cfg), .pll_powered(pll_powered),
    .pll_clk_hold_low(pll_clk_hold_low), .pll_locked(pll_locked), .irq(irq)
  );

  cgopc_clk_src #(.SLOW_PER_NS(SP * 40), .MAIN_PER_NS(MP * 40)) src (
    .osc_enable(main_osc_enable), .osc_bypass(osc_bypass_select),
    .slow_rc_clock(slow_rc_clock), .main_osc_clock(main_osc_clock)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Strobes end one edge later; outputs are looked at on the falling edge
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  function automatic logic pick(input int sel);
    return (sel == 0) ? main_osc_stable : pll_locked;
  endfunction

  task automatic time_to_flag(input int sel, output int cnt);
    cnt = 0;
    while (pick(sel) !== 1'b1 && cnt < 40 * SP)
    begin
      @(negedge clk);
      cnt++;
    end
  endtask

  task automatic reset_and_check();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    // Off, slow clock, divider zero
    check({main_osc_enable, osc_bypass_select, main_osc_stable, main_clk_select,
           pll_powered, pll_clk_hold_low, pll_locked, irq}, 32'h04, "reset outputs");
    foreach (rows[i])
    begin
      reg_read(rows[i].addr, rd);
      check(rd, 32'h0, "reset read");
    end
    $display("Test reset done");
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == TIMEOUT)
    begin
      fail_count++;
      final_report();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fail_count = 0;
    tests_run = 0;
    reset_and_check();
    foreach (rows[i])
    begin
      reg_write(rows[i].addr, rows[i].wdata);
      reg_read(rows[i].addr, rd);
      check(rd, rows[i].rexp, "register row");
    end
    check({osc_bypass_select, main_osc_enable, pll_powered, pll_clk_hold_low},
          32'hB, "row outs");
    $display("Test register rows done");

    // count long enough for the model; rewrite restarts
    reg_write(OFF_OSC_CTRL, 32'h0000_0201);
    repeat (10 * SP) @(negedge clk);
    check(main_osc_stable, 1'b0, "stable early");
    reg_write(OFF_OSC_CTRL, 32'h0000_0101);
    time_to_flag(0, n);
    check(32'(n >= 7 * SP - 2 && n <= 8 * SP + 4), 32'h1, "startup time");
    check(main_clk_select, 1'b1, "clock select");
    reg_write(OFF_IRQ_MASK, 32'h0000_0001);
    check(irq, 1'b1, "stable irq");
    reg_write(OFF_IRQ_MASK, 32'h0000_0000);
    check(irq, 1'b0, "masked irq");
    $display("Test oscillator start done");

    rd = 32'h0;
    k = 0;
    while (rd[FREQ_DONE_BIT] !== 1'b1 && k < 40)
    begin
      repeat (SP) @(negedge clk);
      reg_read(OFF_FREQ, rd);
      k++;
    end
    check(32'(rd[15:0] >= NOM - 4 && rd[15:0] <= NOM + 2), 32'h1, "main count");
    repeat (2 * SP) @(negedge clk);
    reg_read(OFF_FREQ, rd2);
    check(rd2, rd, "count frozen");
    reg_write(OFF_OSC_CTRL, 32'h0000_0000);
    @(negedge clk);
    check({main_osc_enable, main_osc_stable}, 32'h0, "osc off");
    reg_read(OFF_FREQ, rd);
    check(rd, 32'h0, "done cleared");
    $display("Test frequency meter done");

    reg_write(OFF_PLL_CFG, 32'h0004_0805);
    check({pll_powered, pll_clk_hold_low, pll_locked}, 32'h4, "pll start");
    check(pll_cfg, {5'h00, 11'h004, 2'h0, 6'h08, 8'h05}, "pll fields");
    time_to_flag(1, n);
    check(32'(n >= 7 * SP - 2 && n <= 8 * SP + 4), 32'h1, "lock time");
    reg_write(OFF_IRQ_MASK, 32'h0000_0004);
    check(irq, 1'b1, "lock irq");
    reg_write(OFF_PLL_CFG, 32'h0005_0805);
    check(pll_locked, 1'b0, "lock cleared");
    time_to_flag(1, n);
    check(pll_locked, 1'b1, "relock");
    reg_write(OFF_PLL_CFG, 32'h0000_0805);
    repeat (12 * SP) @(negedge clk);
    check({pll_powered, pll_locked, irq}, 32'h0, "pll off");
    reg_write(OFF_PLL_CFG, 32'h0004_0800);
    repeat (12 * SP) @(negedge clk);
    check({pll_powered, pll_clk_hold_low, pll_locked}, 32'h6, "div zero");
    $display("Test pll done");

    reg_write(OFF_OSC_CTRL, 32'h0000_0101);
    reset_and_check();
    final_report();
  end
endmodule
`default_nettype wire
